// *** verilog/roaf_pkg.sv ***
// Constants, register map and carrier types of the reading offset and adaptive filter.
// Assumes one clock; every sample arrives as a one-cycle valid strobe.
package roaf_pkg;
  localparam int SW = 20;
  localparam int OW = 16;
  localparam int DW = 21;
  localparam int AW = 5;
  localparam logic [AW-1:0] ADDR_CTRL = 5'h00;
  localparam logic [AW-1:0] ADDR_BAND = 5'h04;
  localparam logic [AW-1:0] ADDR_OFFSET = 5'h08;
  localparam logic [AW-1:0] ADDR_CMD = 5'h0C;
  localparam logic [AW-1:0] ADDR_DISPLAY = 5'h10;
  localparam logic [AW-1:0] ADDR_STATUS = 5'h14;
  localparam int CTRL_STR_LSB = 0;
  localparam int CTRL_PT_LSB = 2;
  localparam int CTRL_ZFN_BIT = 5;
  localparam int CMD_ZERO_BIT = 0;
  localparam int STAT_BYP_BIT = 0;
  localparam logic [7:0] BAND_MAX = 8'hC7;
  localparam logic [7:0] BAND_RST = 8'h00;
  localparam logic signed [OW-1:0] OFS_MAX = 16'sh4E1F;
  localparam logic signed [OW-1:0] OFS_RST = 16'sh0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    FILT_OFF = 4'h1,
    FILT_Q4 = 4'h2,
    FILT_Q8 = 4'h4,
    FILT_Q16 = 4'h8
  } roaf_filt_e;

  typedef struct packed {
    logic [1:0] strength;
    logic [2:0] pointSel;
    logic zeroReadingFunction;
    logic [7:0] band;
  } roaf_cfg_s;

  typedef struct packed {
    logic valid;
    logic signed [SW-1:0] data;
  } roaf_sample_s;

  typedef struct packed {
    logic valid;
    logic [2:0] point;
    logic signed [DW-1:0] value;
  } roaf_disp_s;

  localparam roaf_cfg_s CFG_RST = '{strength: 2'h0, pointSel: 3'h0,
                                    zeroReadingFunction: 1'b0, band: BAND_RST};
endpackage : roaf_pkg

// *** verilog/roaf_filter.sv ***
// Reading offset, zeroing and adaptive first-order smoothing, with an AXI4-Lite register slave.
// Assumes samples and the user input are synchronous to clk.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: Strengths 0..3; 0 passes reading unfiltered.
// R2: Strength 1: quarter new, three quarters old.
// R3: Strength 2: eighth new, seven eighths old.
// R4: Strength 3: sixteenth new, fifteen sixteenths old.
// R5: Variation above band bypasses; below resumes.
// R6: Band compared in raw display counts.
// R7: Band zero keeps smoothing always on.
// R8: Signed offset within +-19999 added.
// R9: Zero command rewrites offset to shift.
// R10: Zero offset leaves reading unchanged.
// R11: Offset decimal point follows point select.
// R12: User input edge zeroes displayed value.
// R13: One update per sample; display cleared on reset.
module roaf_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Sample stream and user input
  input wire roaf_pkg::roaf_sample_s sample,
  input wire logic userZero,
  // Display side
  output roaf_pkg::roaf_disp_s disp,
  output logic [2:0] offsetPoint,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [roaf_pkg::AW-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [roaf_pkg::AW-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import roaf_pkg::*;

  roaf_cfg_s cfg_r;
  logic signed [OW-1:0] offset_r;
  logic bypass_r;
  logic userZeroPrev_r;
  roaf_disp_s disp_r;
  logic awHeld_r;
  logic wHeld_r;
  logic [AW-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic awReady_r;
  logic wReady_r;
  logic arReady_r;

  logic wrFire;
  logic arFire;
  logic wrMapped;
  logic [31:0] wrMerged;
  logic [31:0] rdWord;
  logic cmdZero;
  logic zeroEv;
  logic signed [DW-1:0] reading;
  logic signed [DW-1:0] prevDisp;
  logic signed [DW:0] diff;
  logic [DW:0] absDiff;
  logic signed [DW:0] step;
  logic signed [DW-1:0] filtered;
  logic signed [DW-1:0] dispNxt;
  logic bypass_nxt;
  logic signed [OW-1:0] offset_nxt;
  roaf_filt_e filtMode;

  // Full bus width so a huge software value saturates instead of wrapping
  function automatic logic signed [OW-1:0] clampOfs(input logic signed [31:0] v);
    if (v > 32'(OFS_MAX)) begin
      return OFS_MAX;
    end
    if (v < -32'(OFS_MAX)) begin
      return -OFS_MAX;
    end
    return v[OW-1:0];
  endfunction : clampOfs

  // AXI handshakes: address and data taken independently, answer once both are held
  assign wrFire = awHeld_r && wHeld_r && !bvalid_r;
  assign arFire = s_axi_arvalid && s_axi_arready;
  assign wrMapped = awAddr_r <= ADDR_CMD && awAddr_r[1:0] == 2'h0;

  always_comb begin
    rdWord = 32'h0000_0000;
    unique case (awAddr_r)
      ADDR_CTRL: rdWord = {26'h0, cfg_r.zeroReadingFunction, cfg_r.pointSel, cfg_r.strength};
      ADDR_BAND: rdWord = {24'h0, cfg_r.band};
      ADDR_OFFSET: rdWord = {{(32-OW){offset_r[OW-1]}}, offset_r};
      default: rdWord = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++) begin
      wrMerged[8*i +: 8] = wStrb_r[i] ? wData_r[8*i +: 8] : rdWord[8*i +: 8];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_r <= 1'b0;
      awReady_r <= 1'b1;
      awAddr_r <= 5'h00;
    end else if (s_axi_awvalid && !awHeld_r) begin
      awHeld_r <= 1'b1;
      awReady_r <= 1'b0;
      awAddr_r <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_r <= 1'b0;
      awReady_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wHeld_r <= 1'b0;
      wReady_r <= 1'b1;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else if (s_axi_wvalid && !wHeld_r) begin
      wHeld_r <= 1'b1;
      wReady_r <= 1'b0;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld_r <= 1'b0;
      wReady_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wrFire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_r <= 1'b0;
      arReady_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (arFire) begin
      rvalid_r <= 1'b1;
      arReady_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL: rdata_r <= {26'h0, cfg_r.zeroReadingFunction, cfg_r.pointSel, cfg_r.strength};
        ADDR_BAND: rdata_r <= {24'h0, cfg_r.band};
        ADDR_OFFSET: rdata_r <= {{(32-OW){offset_r[OW-1]}}, offset_r};
        ADDR_CMD: rdata_r <= 32'h0000_0000;
        ADDR_DISPLAY: rdata_r <= {{(32-DW){disp_r.value[DW-1]}}, disp_r.value};
        ADDR_STATUS: rdata_r <= {31'h0, bypass_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
      arReady_r <= 1'b1;
    end
  end

  // Configuration; band above its top is held at the top
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= CFG_RST;
    end else if (wrFire && awAddr_r == ADDR_CTRL) begin
      cfg_r.strength <= wrMerged[CTRL_STR_LSB +: 2];
      cfg_r.pointSel <= wrMerged[CTRL_PT_LSB +: 3];
      cfg_r.zeroReadingFunction <= wrMerged[CTRL_ZFN_BIT];
    end else if (wrFire && awAddr_r == ADDR_BAND) begin
      cfg_r.band <= (wrMerged > 32'(BAND_MAX)) ? BAND_MAX : wrMerged[7:0];
    end
  end

  // Zero requests: edge of the user input when so assigned, or a software command
  assign cmdZero = wrFire && awAddr_r == ADDR_CMD && wrMerged[CMD_ZERO_BIT];
  assign zeroEv = cmdZero || (cfg_r.zeroReadingFunction && userZero && !userZeroPrev_r); // R12

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      userZeroPrev_r <= 1'b0;
    end else begin
      userZeroPrev_r <= userZero;
    end
  end

  // Zeroing wins over a software offset write in the same cycle
  always_comb begin
    offset_nxt = offset_r;
    if (zeroEv) begin
      offset_nxt = clampOfs(32'(offset_r) - 32'(disp_r.value)); // R9
    end else if (wrFire && awAddr_r == ADDR_OFFSET) begin
      offset_nxt = clampOfs($signed(wrMerged)); // R8
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      offset_r <= OFS_RST;
    end else begin
      offset_r <= offset_nxt;
    end
  end

  // Filter datapath; band is in raw counts, the point position never scales it
  assign reading = DW'(sample.data) + DW'(offset_r); // R8 R10
  assign prevDisp = disp_r.value;
  assign diff = (DW+1)'(reading) - (DW+1)'(prevDisp);
  assign absDiff = diff[DW] ? (DW+1)'(-diff) : (DW+1)'(diff); // R6

  always_comb begin
    unique case (cfg_r.strength)
      2'h0: filtMode = FILT_OFF;
      2'h1: filtMode = FILT_Q4;
      2'h2: filtMode = FILT_Q8;
      2'h3: filtMode = FILT_Q16;
    endcase
  end

  always_comb begin
    step = diff;
    unique case (filtMode)
      FILT_OFF: step = diff; // R1
      FILT_Q4: step = diff >>> 2; // R2
      FILT_Q8: step = diff >>> 3; // R3
      FILT_Q16: step = diff >>> 4; // R4
    endcase
  end

  assign filtered = prevDisp + step[DW-1:0];

  // Band hysteresis: equal to the band keeps the last decision
  always_comb begin
    bypass_nxt = bypass_r;
    if (cfg_r.band == 8'h00) begin
      bypass_nxt = 1'b0; // R7
    end else if (sample.valid && absDiff > (DW+1)'(cfg_r.band)) begin
      bypass_nxt = 1'b1; // R5
    end else if (sample.valid && absDiff < (DW+1)'(cfg_r.band)) begin
      bypass_nxt = 1'b0; // R5
    end
  end

  assign dispNxt = bypass_nxt ? reading : filtered;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bypass_r <= 1'b0;
    end else begin
      bypass_r <= bypass_nxt;
    end
  end

  // A zero request overrides a coincident sample so the display lands exactly on zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      disp_r <= '0; // R13
    end else begin
      disp_r.point <= cfg_r.pointSel;
      disp_r.valid <= zeroEv || sample.valid;
      if (zeroEv) begin
        disp_r.value <= '0; // R12
      end else if (sample.valid) begin
        disp_r.value <= dispNxt; // R13
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      offsetPoint <= 3'h0;
    end else begin
      offsetPoint <= cfg_r.pointSel; // R11
    end
  end

  assign disp = disp_r;
  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  a_pass_through: assert property (@(posedge clk) disable iff (!nrst) // R1
    sample.valid && !zeroEv && filtMode == FILT_OFF |=> disp_r.value == $past(reading))
    else $error("strength zero did not pass reading");
  a_quarter_step: assert property (@(posedge clk) disable iff (!nrst) // R2
    sample.valid && !zeroEv && !bypass_nxt && cfg_r.strength == 2'h1
    |=> disp_r.value == $past(prevDisp) + DW'($past(diff) >>> 2))
    else $error("quarter smoothing wrong");
  a_eighth_step: assert property (@(posedge clk) disable iff (!nrst) // R3
    sample.valid && !zeroEv && !bypass_nxt && cfg_r.strength == 2'h2
    |=> disp_r.value == $past(prevDisp) + DW'($past(diff) >>> 3))
    else $error("eighth smoothing wrong");
  a_sixteenth_step: assert property (@(posedge clk) disable iff (!nrst) // R4
    sample.valid && !zeroEv && !bypass_nxt && cfg_r.strength == 2'h3
    |=> disp_r.value == $past(prevDisp) + DW'($past(diff) >>> 4))
    else $error("sixteenth smoothing wrong");
  a_band_bypass: assert property (@(posedge clk) disable iff (!nrst) // R5
    sample.valid && !zeroEv && cfg_r.band != 8'h00 && absDiff > (DW+1)'(cfg_r.band)
    |=> bypass_r && disp_r.value == $past(reading))
    else $error("large step not bypassed");
  a_band_zero: assert property (@(posedge clk) disable iff (!nrst) // R7
    cfg_r.band == 8'h00 |=> !bypass_r)
    else $error("bypass with band zero");
  a_offset_range: assert property (@(posedge clk) disable iff (!nrst) // R8
    offset_r <= OFS_MAX && offset_r >= -OFS_MAX)
    else $error("offset out of range");
  a_zero_shift: assert property (@(posedge clk) disable iff (!nrst) // R9
    zeroEv |=> disp_r.value == '0 && disp_r.valid)
    else $error("zero request did not zero display");
  a_offset_none: assert property (@(posedge clk) disable iff (!nrst) // R10
    sample.valid && !zeroEv && offset_r == '0 && filtMode == FILT_OFF
    |=> disp_r.value == DW'($past(sample.data)))
    else $error("zero offset changed reading");
  a_one_update: assert property (@(posedge clk) disable iff (!nrst) // R13
    !sample.valid && !zeroEv |=> $stable(disp_r.value) && !disp_r.valid)
    else $error("display moved without sample");
endmodule : roaf_filter

`default_nettype wire

// *** verilog/unused_placeholder_removed.sv ***
// Holds no logic; the filter file carries the whole block.
// Assumes nothing of its surroundings.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/roaf_partner.sv ***
// Sample source upstream of the filter and display downstream of it.
// Assumes one clock; go is a one-cycle request from the bench.
`timescale 1ns/1ps
`default_nettype none
module roaf_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bench request
  input wire logic go,
  input wire logic signed [roaf_pkg::SW-1:0] goData,
  // Filter side
  input wire roaf_pkg::roaf_disp_s disp,
  output roaf_pkg::roaf_sample_s sample,
  // Observed display
  output logic signed [roaf_pkg::DW-1:0] shown,
  output logic updated
);
  import roaf_pkg::*;
  // Idle data toggles so stale data never looks fresh
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sample <= '{valid: 1'b0, data: '1};
    end else if (go) begin
      sample <= '{valid: 1'b1, data: goData};
    end else begin
      sample <= '{valid: 1'b0, data: ~sample.data};
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shown <= '0;
      updated <= 1'b0;
    end else begin
      updated <= disp.valid;
      if (disp.valid) begin
        shown <= disp.value;
      end
    end
  end
endmodule : roaf_partner
`default_nettype wire

// *** tb/tb_roaf_filter.sv ***
// Self-checking bench of the reading offset and adaptive filter.
// Assumes roaf_pkg, the filter and the partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_roaf_filter;
  import roaf_pkg::*;
  typedef struct {int c; int b; int o; int d; int e;} roaf_row_s;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic signed [SW-1:0] goData = '0;
  logic userZero = 1'b0;
  roaf_sample_s sample;
  roaf_disp_s disp;
  logic signed [DW-1:0] shown;
  logic updated;
  logic [2:0] offsetPoint;
  logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  int mismatches = 0, num_checks = 0, cyc = 0;
  // Filter state carries from row to row
  roaf_row_s rows[11] = '{'{0, 0, 0, 1000, 1000}, '{1, 0, 0, 2000, 1250},
    '{2, 0, 0, 2050, 1350}, '{3, 0, 0, 1510, 1360}, '{3, 0, 0, 1343, 1358},
    '{3, 0, 0, 3358, 1483}, '{1, 10, 0, 1583, 1583}, '{1, 10, 0, 1587, 1584},
    '{0, 0, 100, 500, 600}, '{0, 0, 0, 500, 500}, '{13, 10, 0, 520, 520}};

  always #12.5 clk = ~clk;

  roaf_partner partner (.clk(clk), .nrst(nrst), .go(go), .goData(goData), .disp(disp),
    .sample(sample), .shown(shown), .updated(updated));
  roaf_filter dut (.clk(clk), .nrst(nrst), .sample(sample), .userZero(userZero),
    .disp(disp), .offsetPoint(offsetPoint), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp));

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %0t %s", $time, m);
      mismatches++;
    end
  endtask : chk

  // Leading edge keeps a new request off the edge that ended the last
  task wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask : wr

  task rdr(input logic [AW-1:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask : rdr

  task settle();
    for (int i = 0; i < 8 && updated !== 1'b1; i++) @(posedge clk);
  endtask : settle

  task smp(input int d);
    @(posedge clk);
    go <= 1'b1;
    goData <= SW'(d);
    @(posedge clk);
    go <= 1'b0;
    settle();
  endtask : smp

  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    chk(32'(disp.value), 32'h0, "display after reset");
    chk(32'(offsetPoint), 32'h0, "point after reset");
    wr(ADDR_BAND, 32'd250);
    chk(32'(resp), 32'(RESP_OKAY), "write response");
    rdr(ADDR_BAND);
    chk(rd, 32'd199, "band limit");
    wr(ADDR_BAND, 32'h0000_0100);
    rdr(ADDR_BAND);
    chk(rd, 32'd199, "band wide limit");
    wr(ADDR_OFFSET, 32'h0040_0000);
    rdr(ADDR_OFFSET);
    chk(rd, 32'd19999, "offset wide limit");
    wr(ADDR_OFFSET, 32'd30000);
    rdr(ADDR_OFFSET);
    chk(rd, 32'd19999, "offset upper limit");
    wr(ADDR_OFFSET, 32'hFFFF8AD0);
    rdr(ADDR_OFFSET);
    chk(rd, 32'hFFFFB1E1, "offset lower limit");
    rdr(5'h18);
    chk(32'(resp), 32'(RESP_SLVERR), "unmapped read");
    wr(ADDR_STATUS, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR), "unmapped write");
    foreach (rows[i]) begin
      wr(ADDR_CTRL, 32'(rows[i].c));
      wr(ADDR_BAND, 32'(rows[i].b));
      wr(ADDR_OFFSET, 32'(rows[i].o));
      smp(rows[i].d);
      chk(32'(shown), 32'(rows[i].e), "filtered value");
    end
    chk(32'(offsetPoint), 32'h3, "offset point");
    chk(32'(disp.point), 32'h3, "display point");
    rdr(ADDR_STATUS);
    chk(rd, 32'h1, "bypass status");
    rdr(ADDR_DISPLAY);
    chk(rd, 32'd520, "display register");
    wr(ADDR_CMD, 32'h1);
    settle();
    chk(32'(shown), 32'h0, "zero command");
    // User input edge must be ignored while not assigned to zeroing
    @(posedge clk);
    userZero <= 1'b1;
    @(posedge clk);
    userZero <= 1'b0;
    rdr(ADDR_OFFSET);
    chk(rd, 32'hFFFFFDF8, "offset after zero");
    wr(ADDR_CTRL, 32'h20);
    smp(700);
    chk(32'(shown), 32'd180, "offset applied");
    @(posedge clk);
    userZero <= 1'b1;
    settle();
    chk(32'(shown), 32'h0, "user zero");
    rdr(ADDR_OFFSET);
    chk(rd, 32'hFFFFFD44, "offset after user zero");
    userZero <= 1'b0;
    end_of_test();
  end
endmodule : tb_roaf_filter
`default_nettype wire
